// ---- hw/reg_xfer_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface reg_xfer_if;
  logic cmdToggle;
  logic [7:0] cmdByte;
  logic wrToggle;
  logic [23:0] wrWord;
  logic [31:0] rdWord;

  modport link (output cmdToggle, output cmdByte, output wrToggle, output wrWord, input rdWord);
  modport core (input cmdToggle, input cmdByte, input wrToggle, input wrWord, output rdWord);
endinterface

`default_nettype wire

// ---- hw/result_and_checksum_registers.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "result_regs_params.svh"

// Operation
// - checksum is XOR of all user registers
// - checksum only when enabled, else zero
// - offset binary, unipolar when polarity selects
// - reading data drives ready bit/pin high
// - repeated reads allowed, ready stays high
// - no new result during a data read
// - append status makes data read 32 bits, 24 with short word
// - short word bit applies from next result
// - bit 13 enables outputs two and three
module result_and_checksum_registers #(
  parameter int RESULT_BITS = 24,
  parameter int CHANNEL_BITS = 4
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link pins
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // Converter core
  input wire logic convValid,
  input wire logic [RESULT_BITS-1:0] convSample,
  input wire logic [CHANNEL_BITS-1:0] convChannel,
  input wire logic polaritySelect,
  // Pins
  output logic readyN,
  output logic general_output_pin_two,
  output logic general_output_pin_three,
  output logic upper_outputs_enable
);

  // ==========================================================
  // Parameter checks
  if (RESULT_BITS != 24) begin : g_bad_result
    $error("RESULT_BITS must be 24");
  end
  // Status byte has room for seven channel bits beside ready
  if (CHANNEL_BITS < 1 || CHANNEL_BITS > 7) begin : g_bad_channel
    $error("CHANNEL_BITS must be 1..7");
  end

  // ==========================================================
  // Link side and crossings
  reg_xfer_if xfer ();

  serial_link_port u_link (
    .serialClk(serialClk),
    .sysRst(sys_rst),
    .chipSelectN(chipSelectN),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .serialOutEn(serialOutEn),
    .xfer(xfer)
  );

  logic [2:0] syncOut;

  sync_three #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst(sys_rst),
    .async({~chipSelectN, xfer.wrToggle, xfer.cmdToggle}),
    .stable(syncOut)
  );

  // Select goes through true so the synchroniser's reset level matches an idle bus
  wire logic selectSync = syncOut[2];
  wire logic csNSync = ~selectSync;
  wire logic wrTogSync = syncOut[1];
  wire logic cmdTogSync = syncOut[0];

  logic cmdTogSeen_q, wrTogSeen_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdTogSeen_q <= 1'b0;
      wrTogSeen_q <= 1'b0;
    end else begin
      cmdTogSeen_q <= cmdTogSync;
      wrTogSeen_q <= wrTogSync;
    end
  end

  // Link words are held stable from their toggle until the next frame
  wire logic cmdEvent = cmdTogSync ^ cmdTogSeen_q;
  wire logic wrEvent = wrTogSync ^ wrTogSeen_q;
  wire logic [5:0] cmdAddr = xfer.cmdByte[5:0];
  wire logic cmdIsRead = xfer.cmdByte[`CMD_READ_BIT];

  // ==========================================================
  // Access tracking
  result_regs_pkg::access_e acc_q, acc_d;
  logic [5:0] accAddr_q;

  always_comb begin
    acc_d = acc_q;
    case (acc_q)
      result_regs_pkg::ACC_IDLE: begin
        if (cmdEvent) acc_d = cmdIsRead ? result_regs_pkg::ACC_READ : result_regs_pkg::ACC_WRITE;
      end
      result_regs_pkg::ACC_READ: begin
        if (csNSync) acc_d = result_regs_pkg::ACC_IDLE;
      end
      result_regs_pkg::ACC_WRITE: begin
        if (wrEvent || csNSync) acc_d = result_regs_pkg::ACC_IDLE;
      end
      default: acc_d = result_regs_pkg::ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= result_regs_pkg::ACC_IDLE;
      accAddr_q <= 6'h00;
    end else begin
      acc_q <= acc_d;
      if (cmdEvent) accAddr_q <= cmdAddr;
    end
  end

  // Data offset decode, shared by the read command and the hold
  function automatic logic isDataAddr(input logic [5:0] addr);
    return addr == `OFS_DATA;
  endfunction

  // A data read in progress locks the result until deselect
  wire logic dataReadCmd = cmdEvent && cmdIsRead && isDataAddr(cmdAddr);
  wire logic holdResult = (acc_q == result_regs_pkg::ACC_READ) && isDataAddr(accAddr_q);

  // ==========================================================
  // User registers
  logic [15:0] adcMode_q, ifMode_q, pinIo_q;

  wire logic wrAccept = wrEvent && (acc_q == result_regs_pkg::ACC_WRITE);
  wire logic [15:0] wrData16 = xfer.wrWord[15:0];
  // Writes to status, checksum and data land nowhere
  wire logic wrAdcMode = wrAccept && (accAddr_q == `OFS_ADC_MODE);
  wire logic wrIfMode = wrAccept && (accAddr_q == `OFS_IF_MODE);
  wire logic wrPinIo = wrAccept && (accAddr_q == `OFS_PIN_IO);
  wire logic [15:0] ifMode_d = wrData16 & `IFM_WMASK;
  wire logic [15:0] pinIo_d = (wrData16 & `PIO_WMASK) | (pinIo_q & ~`PIO_WMASK);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adcMode_q <= `ADC_MODE_RESET;
    end else if (wrAdcMode) begin
      adcMode_q <= wrData16;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ifMode_q <= `IFM_RESET;
    end else if (wrIfMode) begin
      ifMode_q <= ifMode_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinIo_q <= `PIO_RESET;
    end else if (wrPinIo) begin
      pinIo_q <= pinIo_d;
    end
  end

  wire logic shortWordCfg = ifMode_q[`IFM_SHORT_WORD];
  wire logic checkEnable = ifMode_q[`IFM_CHECK_EN];
  wire logic appendStatus = ifMode_q[`IFM_APPEND_STATUS];

  // ==========================================================
  // Checksum, refreshed every cycle so a read never sees stale contents
  // Status, data and the checksum itself are not user registers and stay out
  logic [23:0] checksum_q;
  wire logic [23:0] checksumAll = {8'h00, adcMode_q} ^ {8'h00, ifMode_q} ^ {8'h00, pinIo_q};
  wire logic [23:0] checksum_d = checkEnable ? checksumAll : 24'h000000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      checksum_q <= 24'h000000;
    end else begin
      checksum_q <= checksum_d;
    end
  end

  // ==========================================================
  // Result coding and capture
  wire logic sampleNeg = convSample[RESULT_BITS-1];
  wire logic [23:0] offsetCode = {~convSample[23], convSample[22:0]};
  // Unipolar range has no room for negative inputs, so they clamp to zero
  wire logic [23:0] unipolarCode = sampleNeg ? 24'h000000 : {convSample[22:0], 1'b0};
  wire logic [23:0] codedSample = polaritySelect ? unipolarCode : offsetCode;

  logic [23:0] result_q;
  logic resultShort_q;
  logic [CHANNEL_BITS-1:0] channel_q;
  logic readyN_q;

  wire logic storeResult = convValid && !holdResult && !dataReadCmd;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q <= `DATA_RESET;
      resultShort_q <= 1'b0;
      channel_q <= '0;
    end else if (storeResult) begin
      // Length is fixed per result; a changed word length shows from the next one
      result_q <= shortWordCfg ? {codedSample[23:8], 8'h00} : codedSample;
      resultShort_q <= shortWordCfg;
      channel_q <= convChannel;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readyN_q <= 1'b1;
    end else if (dataReadCmd) begin
      // Stays high until a new result, even over repeated reads
      readyN_q <= 1'b1;
    end else if (storeResult) begin
      readyN_q <= 1'b0;
    end
  end

  // ==========================================================
  // Read word, left justified for the shifter
  wire logic [7:0] statusByte = {readyN_q, {(7 - CHANNEL_BITS){1'b0}}, channel_q};
  wire logic [31:0] dataWord16 = appendStatus ? {result_q[23:8], statusByte, 8'h00} : {result_q[23:8], 16'h0000};
  wire logic [31:0] dataWord24 = appendStatus ? {result_q, statusByte} : {result_q, 8'h00};
  wire logic [31:0] dataWord = resultShort_q ? dataWord16 : dataWord24;
  // Status read on the fly shows ready as it stands before this read
  logic [31:0] rdWord_d;

  always_comb begin
    case (cmdAddr)
      `OFS_STATUS: rdWord_d = {statusByte, 24'h000000};
      `OFS_ADC_MODE: rdWord_d = {adcMode_q, 16'h0000};
      `OFS_IF_MODE: rdWord_d = {ifMode_q, 16'h0000};
      `OFS_REG_CHECK: rdWord_d = {checksum_q, 8'h00};
      `OFS_DATA: rdWord_d = dataWord;
      `OFS_PIN_IO: rdWord_d = {pinIo_q, 16'h0000};
      default: rdWord_d = 32'h00000000;
    endcase
  end

  logic [31:0] rdWord_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdWord_q <= 32'h00000000;
    end else if (cmdEvent && cmdIsRead) begin
      rdWord_q <= rdWord_d;
    end
  end

  assign xfer.rdWord = rdWord_q;

  // ==========================================================
  // Pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_outputs_enable <= 1'b0;
      readyN <= 1'b1;
    end else begin
      upper_outputs_enable <= pinIo_q[`PIO_UPPER_EN];
      readyN <= readyN_q;
    end
  end

  // Both general outputs follow the same gating, one flop each
  wire logic [1:0] gpoData = {pinIo_q[`PIO_DATA_THREE], pinIo_q[`PIO_DATA_TWO]};
  wire logic [1:0] gpoPins;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_gpo
      logic pin_q;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_q <= 1'b0;
        end else begin
          pin_q <= pinIo_q[`PIO_UPPER_EN] & gpoData[g];
        end
      end
      assign gpoPins[g] = pin_q;
    end
  endgenerate

  assign general_output_pin_two = gpoPins[0];
  assign general_output_pin_three = gpoPins[1];

endmodule

`default_nettype wire

// ---- hw/result_regs_params.svh ----
`ifndef RESULT_REGS_PARAMS_SVH
`define RESULT_REGS_PARAMS_SVH

// ==========================================================
// Register offsets
`define OFS_STATUS 6'h00
`define OFS_ADC_MODE 6'h01
`define OFS_IF_MODE 6'h02
`define OFS_REG_CHECK 6'h03
`define OFS_DATA 6'h04
`define OFS_PIN_IO 6'h06

// ==========================================================
// Command byte fields
`define CMD_READ_BIT 6
`define CMD_BITS 6'h08

// ==========================================================
// Interface mode fields, reset and write mask
`define IFM_SHORT_WORD 0
`define IFM_CHECK_EN 5
`define IFM_APPEND_STATUS 6
`define IFM_RESET 16'h0000
`define IFM_WMASK 16'h006d

// ==========================================================
// Pin configuration fields, reset and write mask
`define PIO_UPPER_EN 13
`define PIO_DATA_THREE 3
`define PIO_DATA_TWO 2
`define PIO_RESET 16'h0800
`define PIO_WMASK 16'h280c

// ==========================================================
// Other resets and status layout
`define ADC_MODE_RESET 16'h0000
`define DATA_RESET 24'h000000
`define STATUS_READY_N 7

`endif

// ---- hw/result_regs_pkg.sv ----
`include "result_regs_params.svh"

package result_regs_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } access_e;

  typedef enum logic {
    PH_COMMAND = 1'b0,
    PH_PAYLOAD = 1'b1
  } phase_e;

  // Payload length in bits of a register transfer
  function automatic logic [5:0] regBits(input logic [5:0] addr, input logic shortWord, input logic append);
    logic [5:0] n;
    n = 6'h08;
    case (addr)
      `OFS_STATUS: n = 6'h08;
      `OFS_ADC_MODE, `OFS_IF_MODE, `OFS_PIN_IO: n = 6'h10;
      `OFS_REG_CHECK: n = 6'h18;
      `OFS_DATA: n = (shortWord ? 6'h10 : 6'h18) + (append ? 6'h08 : 6'h00);
      default: n = 6'h08;
    endcase
    return n;
  endfunction

endpackage

// ---- hw/serial_link_port.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "result_regs_params.svh"

module serial_link_port (
  // Link clock, resets and pins
  input wire logic serialClk,
  input wire logic sysRst,
  input wire logic chipSelectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // Core side
  reg_xfer_if.link xfer
);

  // ==========================================================
  // Frame logic, cleared while the chip is deselected
  wire logic frameRst = sysRst | chipSelectN;
  result_regs_pkg::phase_e phase_q;
  logic [5:0] bitCnt_q;
  logic [6:0] cmdShift_q;
  logic [23:0] wrShift_q;
  logic [31:0] outShift_q;
  logic loaded_q;
  logic cmdToggle_q, wrToggle_q;
  logic [7:0] cmdByte_q;
  logic [23:0] wrWord_q;

  wire logic [7:0] cmdNext = {cmdShift_q, serialIn};
  wire logic isRead = cmdByte_q[`CMD_READ_BIT];
  wire logic [5:0] wrLen = result_regs_pkg::regBits(cmdByte_q[5:0], 1'b0, 1'b0);
  wire logic cmdDone = (phase_q == result_regs_pkg::PH_COMMAND) && (bitCnt_q == `CMD_BITS - 6'h01);
  wire logic wrDone = (phase_q == result_regs_pkg::PH_PAYLOAD) && !isRead && (bitCnt_q == wrLen - 6'h01);
  wire logic [23:0] wrNext = {wrShift_q[22:0], serialIn};

  always_ff @(posedge serialClk or posedge frameRst) begin
    if (frameRst) begin
      phase_q <= result_regs_pkg::PH_COMMAND;
      bitCnt_q <= 6'h00;
      cmdShift_q <= 7'h00;
      wrShift_q <= 24'h000000;
    end else begin
      cmdShift_q <= cmdNext[6:0];
      wrShift_q <= wrNext;
      bitCnt_q <= cmdDone ? 6'h00 : bitCnt_q + 6'h01;
      if (cmdDone) phase_q <= result_regs_pkg::PH_PAYLOAD;
    end
  end

  // Toggles and held words survive deselect so the core never sees a false event
  always_ff @(posedge serialClk or posedge sysRst) begin
    if (sysRst) begin
      cmdToggle_q <= 1'b0;
      wrToggle_q <= 1'b0;
      cmdByte_q <= 8'h00;
      wrWord_q <= 24'h000000;
    end else begin
      if (!chipSelectN && cmdDone) begin
        cmdByte_q <= cmdNext;
        cmdToggle_q <= ~cmdToggle_q;
      end
      if (!chipSelectN && wrDone) begin
        wrWord_q <= wrNext;
        wrToggle_q <= ~wrToggle_q;
      end
    end
  end

  // Read data changes on the falling edge; the core word is settled by then
  always_ff @(negedge serialClk or posedge frameRst) begin
    if (frameRst) begin
      outShift_q <= 32'h00000000;
      loaded_q <= 1'b0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else begin
      serialOutEn <= 1'b1;
      if (phase_q == result_regs_pkg::PH_PAYLOAD && isRead && !loaded_q) begin
        loaded_q <= 1'b1;
        serialOut <= xfer.rdWord[31];
        outShift_q <= {xfer.rdWord[30:0], 1'b0};
      end else if (loaded_q) begin
        serialOut <= outShift_q[31];
        outShift_q <= {outShift_q[30:0], 1'b0};
      end else begin
        serialOut <= 1'b0;
      end
    end
  end

  assign xfer.cmdToggle = cmdToggle_q;
  assign xfer.cmdByte = cmdByte_q;
  assign xfer.wrToggle = wrToggle_q;
  assign xfer.wrWord = wrWord_q;

endmodule

`default_nettype wire

// ---- hw/sync_three.sv ----
`timescale 1ns/100ps
`default_nettype none

module sync_three #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Signals
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] stable
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_three needs WIDTH >= 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1Q, s2Q, s3Q, outQ;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1Q <= 1'b0;
          s2Q <= 1'b0;
          s3Q <= 1'b0;
          outQ <= 1'b0;
        end else begin
          s1Q <= async[i];
          s2Q <= s1Q;
          s3Q <= s2Q;
          // A change counts only once two late stages agree
          if (s2Q == s3Q) outQ <= s3Q;
        end
      end
      assign stable[i] = outQ;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========
// Host on the serial link
module host_model (
  // Link pins
  output logic serialClk,
  output logic chipSelectN,
  output logic serialIn,
  input wire logic serialOut
);
  initial begin
    serialClk = 1'b1;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end

  // One frame: command, then n payload bits right-aligned in wd and rd
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd << (32 - n)};
    rd = 32'h00000000;
    chipSelectN = 1'b0;
    #30;
    for (int i = 0; i < n + 8; i++) begin
      serialClk = 1'b0;
      serialIn = sh[39 - i];
      #15;
      if (i > 7) rd = {rd[30:0], serialOut};
      serialClk = 1'b1;
      #15;
      // Device needs time to fetch the word across domains
      if (i == 7) #75;
    end
    // Released line shows the inverse so stale data is never mistaken for valid
    serialIn = ~serialIn;
    chipSelectN = 1'b1;
    #60;
  endtask
endmodule

`default_nettype wire

// ---- verif/result_regs_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========
// Port checks
module result_regs_asserts #(
  parameter int RESULT_BITS = 24,
  parameter int CHANNEL_BITS = 4
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serialClk,
  // Link
  input wire logic chipSelectN,
  input wire logic serialOut,
  input wire logic serialOutEn,
  // Converter and pins
  input wire logic convValid,
  input wire logic readyN,
  input wire logic general_output_pin_two,
  input wire logic general_output_pin_three,
  input wire logic upper_outputs_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pin_two_gated: assert property (!upper_outputs_enable |-> !general_output_pin_two)
    else $error("pin two driven while disabled");
  a_pin_three_gated: assert property (!upper_outputs_enable |-> !general_output_pin_three)
    else $error("pin three driven while disabled");
  a_ready_fall_cause: assert property ($fell(readyN) |->
    $past(convValid, 1) || $past(convValid, 2) || $past(convValid, 3))
    else $error("ready fell without a new result");
  a_ready_rise_frame: assert property ($rose(readyN) |-> !chipSelectN && !$past(chipSelectN))
    else $error("ready rose outside a read");
  a_new_result_ready: assert property (chipSelectN [*6] ##0 convValid |-> ##[1:3] !readyN)
    else $error("result outside a frame did not lower ready");
  a_idle_quiet: assert property (chipSelectN |-> !serialOutEn && !serialOut)
    else $error("link driven while deselected");
  a_out_on_fall: assert property ($changed(serialOut) |-> !serialClk || chipSelectN)
    else $error("read data changed while link clock high");
  a_enable_on_fall: assert property ($rose(serialOutEn) |-> !serialClk && !chipSelectN)
    else $error("output enable rose outside a falling phase");

  c_ready_fall: cover property ($fell(readyN));
  c_ready_rise: cover property ($rose(readyN));
  c_pins_on: cover property ($rose(upper_outputs_enable));
endmodule

bind result_and_checksum_registers result_regs_asserts #(
  .RESULT_BITS(RESULT_BITS), .CHANNEL_BITS(CHANNEL_BITS)) chk (.clk(clk), .sys_rst(sys_rst),
  .serialClk(serialClk), .chipSelectN(chipSelectN), .serialOut(serialOut), .serialOutEn(serialOutEn),
  .convValid(convValid), .readyN(readyN), .general_output_pin_two(general_output_pin_two),
  .general_output_pin_three(general_output_pin_three), .upper_outputs_enable(upper_outputs_enable));

`default_nettype wire

// ---- verif/test_result_and_checksum_registers.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_result_and_checksum_registers;
  // ==========
  // Stimulus and wiring
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic convValid = 1'b0;
  logic [23:0] convSample = 24'h000000;
  logic [3:0] convChannel = 4'h0;
  logic polaritySelect = 1'b0;
  wire serialClk, chipSelectN, serialIn, serialOut, serialOutEn, readyN, pinTwo, pinThree, pinEn;
  logic [31:0] seed = 32'h0000000d;
  logic [31:0] got;
  logic [31:0] expQ[$];
  int fails = 0;
  int samplesChecked = 0;
  event gotEv;

  always #2.5 clk = ~clk;

  result_and_checksum_registers DUT (.clk(clk), .sys_rst(sys_rst), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .convValid(convValid), .convSample(convSample), .convChannel(convChannel),
    .polaritySelect(polaritySelect), .readyN(readyN), .general_output_pin_two(pinTwo),
    .general_output_pin_three(pinThree), .upper_outputs_enable(pinEn));
  host_model HOST (.serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut));

  // ==========
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [23:0] code(input logic [23:0] s, input logic pol);
    return pol ? (s[23] ? 24'h000000 : {s[22:0], 1'b0}) : s ^ 24'h800000;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samplesChecked++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  always @(gotEv) check(got, expQ.pop_front());

  task automatic rdReg(input logic [5:0] a, input int n, input logic [31:0] want);
    expQ.push_back(want);
    HOST.xfer({2'b01, a}, n, 32'h00000000, got);
    ->gotEv;
  endtask

  task automatic wrReg(input logic [5:0] a, input int n, input logic [31:0] v);
    logic [31:0] unused;
    HOST.xfer({2'b00, a}, n, v, unused);
  endtask

  task automatic conv(input logic [23:0] s, input logic [3:0] ch, input logic pol);
    @(negedge clk);
    convSample = s;
    convChannel = ch;
    polaritySelect = pol;
    convValid = 1'b1;
    @(negedge clk);
    convValid = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========
  // Sequence
  initial begin
    logic [15:0] v;
    logic [15:0] adc;
    logic [23:0] s;
    logic [23:0] r;
    logic [3:0] ch;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    rdReg(6'h03, 24, 32'h00000000);
    rdReg(6'h06, 16, 32'h00000800);
    rdReg(6'h04, 24, 32'h00000000);
    check(32'({pinEn, pinTwo, pinThree}), 32'h00000000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 16'(rnd());
      v[13] = i[0];
      wrReg(6'h06, 16, {16'h0000, v});
      rdReg(6'h06, 16, {16'h0000, v & 16'h280c});
      check(32'({pinEn, pinTwo, pinThree}), 32'({v[13], v[13] & v[2], v[13] & v[3]}));
    end
    $display("test pins done");
    adc = 16'(rnd());
    wrReg(6'h01, 16, {16'h0000, adc});
    rdReg(6'h01, 16, {16'h0000, adc});
    wrReg(6'h02, 16, 32'h00000020);
    rdReg(6'h03, 24, {16'h0000, adc ^ 16'h0020 ^ (v & 16'h280c)});
    adc = ~adc;
    wrReg(6'h01, 16, {16'h0000, adc});
    wrReg(6'h03, 24, 32'h00ffffff);
    rdReg(6'h03, 24, {16'h0000, adc ^ 16'h0020 ^ (v & 16'h280c)});
    wrReg(6'h02, 16, 32'h00000000);
    rdReg(6'h03, 24, 32'h00000000);
    $display("test checksum done");
    for (int i = 0; i < 4; i++) begin
      s = 24'(rnd());
      s[23] = i[1];
      conv(s, 4'h0, i[0]);
      check(32'(readyN), 32'h00000000);
      rdReg(6'h04, 24, {8'h00, code(s, i[0])});
      check(32'(readyN), 32'h00000001);
      rdReg(6'h04, 24, {8'h00, code(s, i[0])});
    end
    r = code(s, 1'b1);
    fork
      rdReg(6'h04, 24, {8'h00, r});
      begin
        #400;
        conv(~s, 4'h0, 1'b1);
      end
    join
    check(32'(readyN), 32'h00000001);
    rdReg(6'h04, 24, {8'h00, r});
    $display("test coding done");
    wrReg(6'h02, 16, 32'h00000041);
    rdReg(6'h02, 16, 32'h00000041);
    ch = 4'(rnd());
    s = 24'(rnd());
    conv(s, ch, 1'b0);
    r = code(s, 1'b0);
    rdReg(6'h04, 24, {8'h00, r[23:8], 4'h0, ch});
    wrReg(6'h02, 16, 32'h00000040);
    conv(~s, ch, 1'b0);
    rdReg(6'h00, 8, {24'h000000, 4'h0, ch});
    rdReg(6'h04, 32, {code(~s, 1'b0), 4'h0, ch});
    rdReg(6'h00, 8, {24'h000000, 4'h8, ch});
    $display("test append done");
    end_sim();
  end

  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule

`default_nettype wire
